// ==== src/csw_pkg.sv ====
package csw_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [11:0] CSW_IDX_REQUEST = 12'h088d;
  localparam logic [11:0] CSW_IDX_CURRENT = 12'h088e;
  localparam logic [11:0] CSW_IDX_CONTROL = 12'h088f;
  localparam logic [11:0] CSW_IDX_STATUS = 12'h0890;
  localparam logic [11:0] CSW_IDX_IRQ = 12'h0898;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int CSW_SRC_LSB = 4;
  localparam int CSW_DIV_LSB = 0;
  localparam int CSW_HOLD_BIT = 7;
  localparam int CSW_PWR_BIT = 6;
  localparam int CSW_DONE_BIT = 4;
  localparam int CSW_NSR_BIT = 3;
  localparam int CSW_EXT_RDY_BIT = 7;
  localparam int CSW_FAST_RDY_BIT = 6;
  localparam int CSW_MED_RDY_BIT = 5;
  localparam int CSW_SLOW_RDY_BIT = 4;
  localparam int CSW_SEC_RDY_BIT = 3;
  localparam int CSW_CONV_RDY_BIT = 2;
  localparam int CSW_MUL_RDY_BIT = 0;
  localparam int CSW_IRQ_BIT = 0;

  // ==========================================================
  // source and divider codes
  // ==========================================================
  localparam logic [2:0] CSW_SRC_EXT = 3'h7;
  localparam logic [2:0] CSW_SRC_FAST = 3'h6;
  localparam logic [2:0] CSW_SRC_SLOW = 3'h5;
  localparam logic [2:0] CSW_SRC_SEC = 3'h4;
  localparam logic [2:0] CSW_SRC_RSV_HI = 3'h3;
  localparam logic [2:0] CSW_SRC_EXT_PLL = 3'h2;
  localparam logic [2:0] CSW_SRC_FAST_PLL = 3'h1;
  localparam logic [2:0] CSW_SRC_RSV_LO = 3'h0;
  localparam logic [3:0] CSW_DIV_MAX = 4'h9;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [3:0] CSW_DIV_RST_FAST = 4'h2;
  localparam logic [3:0] CSW_DIV_RST_OTHER = 4'h0;
  localparam logic CSW_HOLD_RST = 1'b0;
  localparam logic CSW_PWR_RST = 1'b0;
  localparam logic [7:0] CSW_SYNC_RST = 8'h00;

  // ==========================================================
  // switch sequencer states
  // ==========================================================
  typedef enum logic [3:0] {
    CSW_ST_IDLE = 4'b0001,
    CSW_ST_WAIT = 4'b0010,
    CSW_ST_HOLD = 4'b0100,
    CSW_ST_SWAP = 4'b1000
  } csw_state_t;

endpackage : csw_pkg

// ==== src/csw_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// three-stage synchroniser with agreement filter
// ==========================================================
module csw_sync #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // a bit only moves once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;

endmodule : csw_sync

`default_nettype wire

// ==== src/csw_regs.sv ====
`timescale 1ns/1ps
`default_nettype none

// How it works
// - request source in bits 6:4; codes 111,110,101,100,010,001 valid, 011/000 reserved
// - request divider in bits 3:0; code n divides by two to the n, up to 1001; writes store any 4-bit code, 1010-1111 included
// - writes carrying a reserved source code leave the source field unchanged
// - with switch-enable fuse cleared, the request register ignores every write
// - on reset the request source loads from the reset-source fuses
// - on reset divider loads 0010 for source 110, otherwise 0000
// - read-only current register shows active source 6:4 and divider 3:0
// - after reset current fields equal request reset values
// - hold bit set: stop when new source ready, raise flag, stay on old clock
// - hold bit clear: switch as soon as new-source-ready is seen
// - control bit 6 selects secondary oscillator high (1) or low (0) power
// - done flag bit 4 is 1 when request equals current, else 0
// - ready flag bit 3 sets when the requested oscillator is seen ready while switching, and stays set until the swap ends or the request is abandoned
// - without hold the ready flag may last only one cycle
// - status bits 7..3 give external, fast, medium, slow, secondary ready
// - status bit 0 shows multiplier usable: enabled, input ready and locked
// - after a new request the system keeps running on the current source until ready
// - at switch completion current fields update, done sets, ready flag clears
// - switch flag sets with the ready flag and stays until software clears it
module csw_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic switch_enable_fuse,
  input wire logic [2:0] reset_source_fuse,
  input wire logic external_ready,
  input wire logic fast_internal_ready,
  input wire logic medium_internal_ready,
  input wire logic slow_internal_ready,
  input wire logic secondary_ready,
  input wire logic converter_osc_ready,
  input wire logic multiplier_ready,
  output logic [2:0] requested_source_sel,
  output logic [2:0] current_source_sel,
  output logic [3:0] current_divider_sel,
  output logic clock_stall,
  output logic secondary_power_mode,
  output logic switch_irq_flag
);

  // ==========================================================
  // oscillator ready inputs
  // ==========================================================
  logic [7:0] rdy_raw;
  logic [7:0] rdy_s;

  always_comb begin
    rdy_raw = 8'h00;
    rdy_raw[csw_pkg::CSW_EXT_RDY_BIT] = external_ready;
    rdy_raw[csw_pkg::CSW_FAST_RDY_BIT] = fast_internal_ready;
    rdy_raw[csw_pkg::CSW_MED_RDY_BIT] = medium_internal_ready;
    rdy_raw[csw_pkg::CSW_SLOW_RDY_BIT] = slow_internal_ready;
    rdy_raw[csw_pkg::CSW_SEC_RDY_BIT] = secondary_ready;
    rdy_raw[csw_pkg::CSW_CONV_RDY_BIT] = converter_osc_ready;
    // the multiplier reports usable only when enabled, fed and locked
    rdy_raw[csw_pkg::CSW_MUL_RDY_BIT] = multiplier_ready;
  end

  csw_sync #(
    .W(8)
  ) u_rdy_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in(rdy_raw),
    .sync_out(rdy_s)
  );

  // ==========================================================
  // ahb-lite slave: writes zero wait, reads one wait state
  // ==========================================================
  logic wr_pend_q;
  logic wr_pend_d;
  logic rd_pend_q;
  logic rd_pend_d;
  logic [11:0] idx_q;
  logic [11:0] idx_d;
  logic idx_ok_q;
  logic idx_ok_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic take;

  assign take = hsel && hready && htrans[1];
  assign hresp = 1'b0;
  // a read holds the bus one cycle so hrdata comes from a flop
  assign hreadyout = !rd_pend_q;
  assign hrdata = hrdata_q;

  always_comb begin
    wr_pend_d = take && hwrite;
    rd_pend_d = take && !hwrite;
    idx_d = take ? haddr[13:2] : idx_q;
    idx_ok_d = take ? (haddr[31:14] == 18'h0_0000) && (haddr[1:0] == 2'h0) : idx_ok_q;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= 12'h0000;
      idx_ok_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      idx_q <= idx_d;
      idx_ok_q <= idx_ok_d;
      hrdata_q <= hrdata_d;
    end
  end

  logic wr_req;
  logic wr_ctl;
  logic wr_irq;

  assign wr_req = wr_pend_q && idx_ok_q && (idx_q == csw_pkg::CSW_IDX_REQUEST);
  assign wr_ctl = wr_pend_q && idx_ok_q && (idx_q == csw_pkg::CSW_IDX_CONTROL);
  assign wr_irq = wr_pend_q && idx_ok_q && (idx_q == csw_pkg::CSW_IDX_IRQ);

  // ==========================================================
  // request, current and control state
  // ==========================================================
  logic [2:0] req_src_q;
  logic [2:0] req_src_d;
  logic [3:0] req_div_q;
  logic [3:0] req_div_d;
  logic [2:0] cur_src_q;
  logic [2:0] cur_src_d;
  logic [3:0] cur_div_q;
  logic [3:0] cur_div_d;
  logic hold_q;
  logic hold_d;
  logic pwr_q;
  logic pwr_d;
  logic irq_q;
  logic irq_d;
  logic wr_en_q;
  csw_pkg::csw_state_t st_q;
  csw_pkg::csw_state_t st_d;
  logic [2:0] tgt_src_q;
  logic [2:0] tgt_src_d;
  logic [3:0] tgt_div_q;
  logic [3:0] tgt_div_d;
  logic [3:0] div_rst;
  logic [2:0] wr_src;
  logic src_rsv;
  logic pending;
  logic new_rdy;
  logic nsr;
  logic done;
  logic req_moved;

  assign div_rst = (reset_source_fuse == csw_pkg::CSW_SRC_FAST) ?
                   csw_pkg::CSW_DIV_RST_FAST : csw_pkg::CSW_DIV_RST_OTHER;
  assign wr_src = hwdata[csw_pkg::CSW_SRC_LSB +: 3];
  assign src_rsv = (wr_src == csw_pkg::CSW_SRC_RSV_HI) ||
                   (wr_src == csw_pkg::CSW_SRC_RSV_LO);
  assign pending = (req_src_q != cur_src_q) || (req_div_q != cur_div_q);
  assign done = !pending;
  assign req_moved = (req_src_q != tgt_src_q) || (req_div_q != tgt_div_q);

  // ready of the oscillator the request points at
  always_comb begin
    case (req_src_q)
      csw_pkg::CSW_SRC_EXT: new_rdy = rdy_s[csw_pkg::CSW_EXT_RDY_BIT];
      csw_pkg::CSW_SRC_FAST: new_rdy = rdy_s[csw_pkg::CSW_FAST_RDY_BIT];
      csw_pkg::CSW_SRC_SLOW: new_rdy = rdy_s[csw_pkg::CSW_SLOW_RDY_BIT];
      csw_pkg::CSW_SRC_SEC: new_rdy = rdy_s[csw_pkg::CSW_SEC_RDY_BIT];
      csw_pkg::CSW_SRC_EXT_PLL: new_rdy = rdy_s[csw_pkg::CSW_EXT_RDY_BIT] &&
                                          rdy_s[csw_pkg::CSW_MUL_RDY_BIT];
      csw_pkg::CSW_SRC_FAST_PLL: new_rdy = rdy_s[csw_pkg::CSW_FAST_RDY_BIT] &&
                                           rdy_s[csw_pkg::CSW_MUL_RDY_BIT];
      default: new_rdy = 1'b0;
    endcase
  end

  // the flag stands in the stopped state and during the swap cycle
  assign nsr = (st_q == csw_pkg::CSW_ST_HOLD) || (st_q == csw_pkg::CSW_ST_SWAP);

  always_comb begin
    req_src_d = req_src_q;
    req_div_d = req_div_q;
    hold_d = hold_q;
    pwr_d = pwr_q;
    // only a switch-enabled part accepts new requests
    if (wr_req && wr_en_q) begin
      if (!src_rsv) begin
        req_src_d = wr_src;
      end
      req_div_d = hwdata[csw_pkg::CSW_DIV_LSB +: 4];
    end
    if (wr_ctl) begin
      hold_d = hwdata[csw_pkg::CSW_HOLD_BIT];
      pwr_d = hwdata[csw_pkg::CSW_PWR_BIT];
    end
  end

  // ==========================================================
  // switch sequencer
  // ==========================================================
  always_comb begin
    st_d = st_q;
    cur_src_d = cur_src_q;
    cur_div_d = cur_div_q;
    tgt_src_d = tgt_src_q;
    tgt_div_d = tgt_div_q;
    irq_d = irq_q;
    // software clears with a one; a same-cycle set below still wins
    if (wr_irq && hwdata[csw_pkg::CSW_IRQ_BIT]) begin
      irq_d = 1'b0;
    end
    case (st_q)
      csw_pkg::CSW_ST_IDLE: begin
        if (pending) begin
          st_d = csw_pkg::CSW_ST_WAIT;
        end
      end
      csw_pkg::CSW_ST_WAIT: begin
        if (!pending) begin
          st_d = csw_pkg::CSW_ST_IDLE;
        end else if (new_rdy) begin
          tgt_src_d = req_src_q;
          tgt_div_d = req_div_q;
          irq_d = 1'b1;
          st_d = hold_q ? csw_pkg::CSW_ST_HOLD : csw_pkg::CSW_ST_SWAP;
        end
      end
      csw_pkg::CSW_ST_HOLD: begin
        // stay on the old clock until released or the request is abandoned
        if (!pending) begin
          st_d = csw_pkg::CSW_ST_IDLE;
        end else if (req_moved) begin
          st_d = csw_pkg::CSW_ST_WAIT;
        end else if (!hold_q) begin
          st_d = csw_pkg::CSW_ST_SWAP;
        end
      end
      csw_pkg::CSW_ST_SWAP: begin
        // a request rewritten during the stalled cycle is taken next time
        cur_src_d = tgt_src_q;
        cur_div_d = tgt_div_q;
        st_d = csw_pkg::CSW_ST_IDLE;
      end
      default: begin
        st_d = csw_pkg::CSW_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      req_src_q <= reset_source_fuse;
      req_div_q <= div_rst;
      cur_src_q <= reset_source_fuse;
      cur_div_q <= div_rst;
      tgt_src_q <= reset_source_fuse;
      tgt_div_q <= div_rst;
      wr_en_q <= switch_enable_fuse;
      hold_q <= csw_pkg::CSW_HOLD_RST;
      pwr_q <= csw_pkg::CSW_PWR_RST;
      irq_q <= 1'b0;
      st_q <= csw_pkg::CSW_ST_IDLE;
    end else begin
      req_src_q <= req_src_d;
      req_div_q <= req_div_d;
      cur_src_q <= cur_src_d;
      cur_div_q <= cur_div_d;
      tgt_src_q <= tgt_src_d;
      tgt_div_q <= tgt_div_d;
      wr_en_q <= wr_en_q;
      hold_q <= hold_d;
      pwr_q <= pwr_d;
      irq_q <= irq_d;
      st_q <= st_d;
    end
  end

  // ==========================================================
  // clock mux drive
  // ==========================================================
  // the mux select only moves while the system clock is stalled, so
  // the downstream mux never sees a select change under a live edge
  assign clock_stall = (st_q == csw_pkg::CSW_ST_SWAP);
  assign current_source_sel = cur_src_q;
  assign current_divider_sel = cur_div_q;
  assign requested_source_sel = req_src_q;
  assign secondary_power_mode = pwr_q;
  assign switch_irq_flag = irq_q;

  // ==========================================================
  // read mux
  // ==========================================================
  always_comb begin
    hrdata_d = hrdata_q;
    if (rd_pend_d) begin
      hrdata_d = 32'h0000_0000;
      if ((haddr[31:14] == 18'h0_0000) && (haddr[1:0] == 2'h0)) begin
        case (haddr[13:2])
          csw_pkg::CSW_IDX_REQUEST: begin
            hrdata_d[csw_pkg::CSW_SRC_LSB +: 3] = req_src_q;
            hrdata_d[csw_pkg::CSW_DIV_LSB +: 4] = req_div_q;
          end
          csw_pkg::CSW_IDX_CURRENT: begin
            hrdata_d[csw_pkg::CSW_SRC_LSB +: 3] = cur_src_q;
            hrdata_d[csw_pkg::CSW_DIV_LSB +: 4] = cur_div_q;
          end
          csw_pkg::CSW_IDX_CONTROL: begin
            hrdata_d[csw_pkg::CSW_HOLD_BIT] = hold_q;
            hrdata_d[csw_pkg::CSW_PWR_BIT] = pwr_q;
            hrdata_d[csw_pkg::CSW_DONE_BIT] = done;
            hrdata_d[csw_pkg::CSW_NSR_BIT] = nsr;
          end
          csw_pkg::CSW_IDX_STATUS: begin
            hrdata_d[7:0] = rdy_s;
            hrdata_d[1] = 1'b0;
          end
          csw_pkg::CSW_IDX_IRQ: begin
            hrdata_d[csw_pkg::CSW_IRQ_BIT] = irq_q;
          end
          default: begin
            hrdata_d = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, hwdata[31:8]};

endmodule : csw_regs

`default_nettype wire

// ==== verif/csw_regs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// switch checker
// ==========================================================
module csw_regs_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [2:0] reset_source_fuse,
  input wire logic [2:0] requested_source_sel,
  input wire logic [2:0] current_source_sel,
  input wire logic [3:0] current_divider_sel,
  input wire logic clock_stall,
  input wire logic secondary_power_mode,
  input wire logic switch_irq_flag
);
  localparam logic [31:0] A_REQ = {18'h0, csw_pkg::CSW_IDX_REQUEST, 2'b00};
  localparam logic [31:0] A_CTL = {18'h0, csw_pkg::CSW_IDX_CONTROL, 2'b00};
  localparam logic [31:0] A_IRQ = {18'h0, csw_pkg::CSW_IDX_IRQ, 2'b00};
  logic tk;
  logic wr_q;
  logic [31:0] a_q;
  assign tk = hsel && hready && htrans[1];
  // remember the address phase so data-phase effects can be traced to it
  always_ff @(posedge mclk) begin
    wr_q <= tk && hwrite;
    a_q <= haddr;
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  AST_HRESP: assert property (hresp == 1'b0) else $error("response not okay");
  AST_RD_WAIT: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_RST_VAL: assert property ($fell(rst) |-> requested_source_sel == reset_source_fuse
    && current_source_sel == reset_source_fuse
    && current_divider_sel == (reset_source_fuse == 3'h6 ? 4'h2 : 4'h0))
    else $error("reset values wrong");
  AST_REQ_OK: assert property (requested_source_sel != 3'h3 && requested_source_sel != 3'h0)
    else $error("reserved source stored");
  AST_REQ_SRC: assert property ($changed(requested_source_sel) |->
    $past(wr_q) && $past(a_q) == A_REQ) else $error("request moved without write");
  AST_CUR_HOLD: assert property ($changed({current_source_sel, current_divider_sel}) |->
    $past(clock_stall)) else $error("current moved outside swap");
  AST_CUR_NEW: assert property ($past(clock_stall) |->
    current_source_sel == $past(requested_source_sel)) else $error("swap to wrong source");
  AST_STALL_ONE: assert property (clock_stall |=> !clock_stall)
    else $error("stall longer than one cycle");
  AST_IRQ_SET: assert property (clock_stall |-> switch_irq_flag)
    else $error("flag missing at swap");
  AST_IRQ_CLR: assert property ($fell(switch_irq_flag) |-> $past(wr_q)
    && $past(a_q) == A_IRQ && $past(hwdata[0])) else $error("flag cleared by itself");
  AST_PWR: assert property ($changed(secondary_power_mode) |->
    $past(wr_q) && $past(a_q) == A_CTL) else $error("power mode moved without write");
  COV_SWAP: cover property (clock_stall);
  COV_CLR: cover property ($fell(switch_irq_flag));
  COV_RD: cover property (tk && !hwrite);
endmodule : csw_regs_monitor

bind csw_regs csw_regs_monitor u_mon (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .reset_source_fuse, .requested_source_sel,
  .current_source_sel, .current_divider_sel, .clock_stall, .secondary_power_mode,
  .switch_irq_flag);

`default_nettype wire

// ==== verif/csw_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module csw_regs_tb;
  localparam logic [31:0] A_REQ = {18'h0, csw_pkg::CSW_IDX_REQUEST, 2'b00};
  localparam logic [31:0] A_CUR = {18'h0, csw_pkg::CSW_IDX_CURRENT, 2'b00};
  localparam logic [31:0] A_CTL = {18'h0, csw_pkg::CSW_IDX_CONTROL, 2'b00};
  localparam logic [31:0] A_STA = {18'h0, csw_pkg::CSW_IDX_STATUS, 2'b00};
  localparam logic [31:0] A_IRQ = {18'h0, csw_pkg::CSW_IDX_IRQ, 2'b00};
  localparam logic [2:0] SRCS [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic en = 1'b0;
  logic [2:0] fuse = 3'h5;
  logic [6:0] rdy = 7'h00;
  logic hreadyout;
  logic hresp;
  logic stall;
  logic pwr;
  logic irq;
  logic [31:0] hrdata;
  logic [2:0] req_src;
  logic [2:0] cur_src;
  logic [3:0] cur_div;
  logic hr_n;
  logic [31:0] rd_n;
  logic rd_dp = 1'b0;
  logic [31:0] q [$];
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;

  always #25 mclk = ~mclk;

  csw_regs DUT (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .switch_enable_fuse(en),
    .reset_source_fuse(fuse), .external_ready(rdy[6]), .fast_internal_ready(rdy[5]),
    .medium_internal_ready(rdy[4]), .slow_internal_ready(rdy[3]),
    .secondary_ready(rdy[2]), .converter_osc_ready(rdy[1]), .multiplier_ready(rdy[0]),
    .requested_source_sel(req_src), .current_source_sel(cur_src),
    .current_divider_sel(cur_div), .clock_stall(stall), .secondary_power_mode(pwr),
    .switch_irq_flag(irq));

  // ==========================================================
  // tasks
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("mismatches=%0d comparisons=%0d", n_fail, check_count);
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  // called just after a rising edge; waits on ready with no assumed latency
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge mclk); while (hr_n !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hr_n !== 1'b1);
  endtask : bus

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    q.push_back(exp);
    bus(a, 1'b0, 32'h0);
  endtask : rd

  task automatic rst_seq(input logic e, input logic [2:0] f);
    rst <= 1'b1;
    en <= e;
    fuse <= f;
    idle(3);
    rst <= 1'b0;
    idle(2);
  endtask : rst_seq

  // ==========================================================
  // result watcher
  // ==========================================================
  // values just before each edge, so edge-time updates never race the compare
  always @(negedge mclk) begin
    hr_n <= hreadyout;
    rd_n <= hrdata;
  end

  always @(posedge mclk) begin
    if (rd_dp && hr_n) begin
      check(rd_n, q.pop_front());
      rd_dp = 1'b0;
    end
    if (hsel && hr_n && htrans[1] && !hwrite) rd_dp = 1'b1;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  // ==========================================================
  // scenarios
  // ==========================================================
  initial begin
    logic [3:0] d;
    void'($urandom(38455));
    rst_seq(1'b0, 3'h5);
    rdy <= 7'($urandom);
    // synchroniser needs a few edges before status settles
    idle(6);
    rd(A_STA, {24'h0, rdy[6:1], 1'b0, rdy[0]});
    rd(A_REQ, 32'h50);
    bus(A_REQ, 1'b1, 32'h71);
    rd(A_REQ, 32'h50);
    rd(A_CUR, 32'h50);
    bus(32'h2244, 1'b1, 32'hff);
    rd(32'h2244, 32'h0);
    rst_seq(1'b1, 3'h6);
    rdy <= 7'h3f;
    idle(6);
    rd(A_REQ, 32'h62);
    rd(A_CUR, 32'h62);
    rd(A_CTL, 32'h10);
    for (int i = 0; i < 2; i++) begin
      bus(A_REQ, 1'b1, i ? 32'h04 : 32'h35);
      rd(A_REQ, i ? 32'h64 : 32'h65);
      idle(10);
      rd(A_CUR, i ? 32'h64 : 32'h65);
    end
    // the two switches above left the flag set; clear it so the wait below shows none
    bus(A_IRQ, 1'b1, 32'h1);
    bus(A_REQ, 1'b1, 32'h70);
    idle(10);
    rd(A_CUR, 32'h64);
    rd(A_CTL, 32'h00);
    rd(A_IRQ, 32'h0);
    rdy <= 7'h7f;
    idle(10);
    rd(A_CUR, 32'h70);
    rd(A_CTL, 32'h10);
    rd(A_IRQ, 32'h1);
    check(32'(irq), 32'h1);
    bus(A_IRQ, 1'b1, 32'h1);
    rd(A_IRQ, 32'h0);
    bus(A_CTL, 1'b1, 32'hc0);
    idle(1);
    check(32'(pwr), 32'h1);
    bus(A_REQ, 1'b1, 32'h60);
    idle(10);
    rd(A_CUR, 32'h70);
    rd(A_CTL, 32'hc8);
    rd(A_IRQ, 32'h1);
    bus(A_CTL, 1'b1, 32'h40);
    idle(10);
    rd(A_CUR, 32'h60);
    rd(A_CTL, 32'h50);
    for (int i = 0; i < 6; i++) begin
      d = 4'($urandom % 10);
      bus(A_REQ, 1'b1, {24'h0, 1'b0, SRCS[i], d});
      idle(12);
      rd(A_CUR, {24'h0, 1'b0, SRCS[i], d});
      check({22'h0, req_src, cur_src, cur_div}, {22'h0, SRCS[i], SRCS[i], d});
    end
    idle(3);
    summarize();
  end
endmodule : csw_regs_tb

`default_nettype wire
